//--- rtl/crp_regs.sv
// Record path and power control registers reached over the serial link
//
// Operation
// - Three-bit source code picks one ADC input
// - Gain mute bit silences both ADC inputs
// - Four-bit per-channel gain, 1.5 dB steps
// - Record gain resets to 8000h
// - Mono output from mixer or mic boost
// - Mic select picks second or first mic
// - Loopback feeds ADC samples to DACs
// - Amplifier pin mirrors powerdown top bit
// - Exclusive bit set forces amplifier bit zero
// - Headphone amplifier powerdown bit
// - Clock disable cleared only by cold reset
// - Link powerdown, woken by SYNC warm reset
// - Mixer powerdown with or without reference
// - DAC powerdown and ADC powerdown bits
// - No capture data before ADC ready
// - Four read-only ready flags in low bits
// - Powerdown register resets to 000Fh
// - Identity field latched from pins at power-up
// - Revision field always reads 01
// - Slot-mapping capability bit always reads 1
// - Separate left and right source selectors
`timescale 1ns/10ps
`include "crp_params.svh"

module crp_regs (
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic                      bit_clk_in,
  input  wire logic                      sync_in,
  input  wire logic                      sdata_out_in,
  output logic                           sdata_in_out,
  input  wire logic [1:0]                codec_id_pins_in,
  input  wire logic                      serial_port_exclusive_bit_in,
  input  wire logic [3:0]                ready_flags_in,
  output crp_pkg::crp_record_ctrl_t      record_ctrl_out,
  output crp_pkg::crp_power_ctrl_t       power_ctrl_out,
  output logic                           ext_amp_powerdown_out,
  output logic                           adc_capture_valid_out,
  output logic                           dac_accept_out
);
  import crp_pkg::*;

  // ---------------- Core domain (clock_in) ----------------
  logic [15:0] insel_r;
  logic [15:0] gain_r;
  logic [15:0] path_r;
  logic [7:0]  pwr_r;
  logic [7:0]  pwr_nxt;
  logic [3:0]  rdy_r;
  logic [3:0]  rdy_nxt;
  logic [3:0]  rdy_s1_r;
  logic [3:0]  rdy_s2_r;
  logic [3:0]  rdy_s3_r;
  logic        req_tgl_r;
  logic [2:0]  req_s_r;
  logic        req_seen_r;
  logic        req_f;
  logic        req_evt;
  logic        ack_tgl_r;
  logic [15:0] rdata_r;
  logic [2:0]  wake_s_r;
  logic        wake;
  logic [1:0]  id_s1_r;
  logic [1:0]  id_s2_r;
  logic [1:0]  id_s3_r;
  logic [1:0]  codec_id_r;
  logic [1:0]  strap_cnt_r;
  logic        strap_done_r;
  logic        capture_valid_r;
  logic        dac_accept_r;
  logic        ext_amp_r;
  crp_cmd_t    cmd_r;
  logic        wr;
  logic        wr_insel;
  logic        wr_gain;
  logic        wr_path;
  logic        wr_pwr;
  logic [15:0] wdata;
  logic [15:0] rd_word;

  // Filtered view of a three-stage synchroniser: take stage three once
  // stages two and three agree, otherwise hold the previous value
  function automatic logic [3:0] agree(input logic [3:0] s2,
                                       input logic [3:0] s3,
                                       input logic [3:0] prev);
    agree = (s2 & s3) | (prev & (s2 | s3));
  endfunction

  function automatic logic [15:0] read_mux(input logic [6:0] idx,
                                           input logic [15:0] insel,
                                           input logic [15:0] gain,
                                           input logic [15:0] path,
                                           input logic [7:0]  pwr,
                                           input logic [3:0]  rdy,
                                           input logic [1:0]  cid,
                                           input logic        excl);
    logic [7:0] pwr_rd;
    pwr_rd = pwr;
    if (excl)
      pwr_rd[`CRP_PWR_EXT_AMP] = 1'b0;
    unique case (idx)
      `CRP_IDX_INPUT_SEL:   read_mux = insel;
      `CRP_IDX_RECORD_GAIN: read_mux = gain;
      `CRP_IDX_PATH_SEL:    read_mux = path;
      `CRP_IDX_POWER:       read_mux = {pwr_rd, 4'h0, rdy};
      `CRP_IDX_EXT_ID:      read_mux = {cid, 2'h0, `CRP_SPEC_REV,
                                        1'b1, 9'h000};
      default:              read_mux = 16'h0000;
    endcase
  endfunction

  assign req_f    = (req_s_r[1] == req_s_r[2]) ? req_s_r[2] : req_seen_r;
  assign req_evt  = req_f != req_seen_r;
  assign wr       = req_evt & ~cmd_r.rd;
  assign wdata    = cmd_r.data;
  assign wr_insel = wr & (cmd_r.index == `CRP_IDX_INPUT_SEL);
  assign wr_gain  = wr & (cmd_r.index == `CRP_IDX_RECORD_GAIN);
  assign wr_path  = wr & (cmd_r.index == `CRP_IDX_PATH_SEL);
  assign wr_pwr   = wr & (cmd_r.index == `CRP_IDX_POWER);
  assign wake     = wake_s_r[1] & wake_s_r[2];
  assign rdy_nxt  = agree(rdy_s2_r, rdy_s3_r, rdy_r);
  assign rd_word  = read_mux(cmd_r.index, insel_r, gain_r, path_r, pwr_r,
                             rdy_r, codec_id_r,
                             serial_port_exclusive_bit_in);

  // Power control: only the top byte is writable; ready flags are not
  always_comb begin
    pwr_nxt = wr_pwr ? wdata[15:8] : pwr_r;
    // Clock disable cannot be cleared by software
    pwr_nxt[`CRP_PWR_ICLK] = pwr_nxt[`CRP_PWR_ICLK] |
                             pwr_r[`CRP_PWR_ICLK];
    if (wake & pwr_r[`CRP_PWR_LINK])
      pwr_nxt[`CRP_PWR_LINK] = 1'b0;
    if (serial_port_exclusive_bit_in)
      pwr_nxt[`CRP_PWR_EXT_AMP] = 1'b0;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      insel_r <= `CRP_RST_INPUT_SEL;
      gain_r  <= `CRP_RST_RECORD_GAIN;
      path_r  <= `CRP_RST_PATH_SEL;
      pwr_r   <= `CRP_RST_POWER_CTRL;
    end else begin
      if (wr_insel)
        insel_r <= wdata & `CRP_WMASK_INPUT_SEL;
      if (wr_gain)
        gain_r <= wdata & `CRP_WMASK_GAIN;
      if (wr_path)
        path_r <= wdata & `CRP_WMASK_PATH;
      pwr_r <= pwr_nxt;
    end
  end

  // Ready flags come from analog blocks on their own timing
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdy_s1_r <= `CRP_RST_READY;
      rdy_s2_r <= `CRP_RST_READY;
      rdy_s3_r <= `CRP_RST_READY;
      rdy_r    <= `CRP_RST_READY;
    end else begin
      rdy_s1_r <= ready_flags_in;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
      rdy_r    <= rdy_nxt;
    end
  end

  // Capture data only once the ADCs report ready and are powered
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      capture_valid_r <= 1'b0;
      dac_accept_r    <= 1'b0;
      ext_amp_r       <= 1'b0;
    end else begin
      capture_valid_r <= rdy_r[`CRP_RDY_ADC] & ~pwr_r[0];
      dac_accept_r    <= rdy_r[`CRP_RDY_DAC] & ~pwr_r[1];
      ext_amp_r       <= pwr_nxt[`CRP_PWR_EXT_AMP];
    end
  end

  // Command handshake from the link domain
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      req_s_r    <= 3'h0;
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
      rdata_r    <= 16'h0000;
    end else begin
      req_s_r <= {req_s_r[1:0], req_tgl_r};
      if (req_evt) begin
        req_seen_r <= req_f;
        ack_tgl_r  <= req_f;
        rdata_r    <= rd_word;
      end
    end
  end

  // SYNC seen in the core domain restarts a powered-down link
  always_ff @(posedge clock_in) begin
    if (rst_in)
      wake_s_r <= 3'h0;
    else
      wake_s_r <= {wake_s_r[1:0], sync_in};
  end

  // Identity pins are sampled a few cycles after cold reset, then frozen
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      id_s1_r      <= 2'h0;
      id_s2_r      <= 2'h0;
      id_s3_r      <= 2'h0;
      codec_id_r   <= 2'h0;
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
    end else begin
      id_s1_r <= codec_id_pins_in;
      id_s2_r <= id_s1_r;
      id_s3_r <= id_s2_r;
      if (!strap_done_r) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        if (strap_cnt_r == `CRP_STRAP_DELAY && id_s2_r == id_s3_r) begin
          codec_id_r   <= id_s3_r;
          strap_done_r <= 1'b1;
        end
      end
    end
  end

  assign record_ctrl_out.left_source_sel       = insel_r[10:8];
  assign record_ctrl_out.right_source_sel      = insel_r[2:0];
  assign record_ctrl_out.left_record_gain      = gain_r[11:8];
  assign record_ctrl_out.right_record_gain     = gain_r[3:0];
  assign record_ctrl_out.adc_input_mute        = gain_r[`CRP_BIT_MUTE];
  assign record_ctrl_out.mono_from_mic         = path_r[`CRP_BIT_MONO_SRC];
  assign record_ctrl_out.mic_input_sel         = path_r[`CRP_BIT_MIC_SEL];
  assign record_ctrl_out.converter_loopback_en = path_r[`CRP_BIT_LOOPBACK];
  assign power_ctrl_out.ext_amp_powerdown      = pwr_r[7];
  assign power_ctrl_out.headphone_amp_off      = pwr_r[6];
  assign power_ctrl_out.internal_clock_off     = pwr_r[5];
  assign power_ctrl_out.link_powerdown         = pwr_r[4];
  assign power_ctrl_out.mixer_and_vref_off     = pwr_r[3];
  assign power_ctrl_out.mixer_off_vref_on      = pwr_r[2];
  assign power_ctrl_out.dac_powerdown          = pwr_r[1];
  assign power_ctrl_out.adc_powerdown          = pwr_r[0];
  assign ext_amp_powerdown_out                 = ext_amp_r;
  assign adc_capture_valid_out                 = capture_valid_r;
  assign dac_accept_out                        = dac_accept_r;

  // ---------------- Link domain (bit_clk_in) ----------------
  logic [1:0]  lrst_s_r;
  logic        lrst;
  logic        sync_prev_r;
  logic        frame_start;
  logic [7:0]  bit_cnt_r;
  logic [54:0] in_sh_r;
  logic [55:0] in_word;
  logic [55:0] out_word;
  logic [55:0] out_sh_r;
  logic        sdata_r;
  logic [2:0]  ack_s_r;
  logic        ack_seen_r;
  logic        ack_f;
  logic        ack_evt;
  logic        busy;
  logic        cmd_take;
  logic        reply_pend_r;
  logic [6:0]  reply_idx_r;
  logic [15:0] reply_data_r;

  assign lrst        = lrst_s_r[1];
  assign frame_start = sync_in & ~sync_prev_r;
  assign in_word     = {in_sh_r, sdata_out_in};
  assign ack_f       = (ack_s_r[1] == ack_s_r[2]) ? ack_s_r[2] : ack_seen_r;
  assign ack_evt     = ack_f != ack_seen_r;
  assign busy        = req_tgl_r != ack_seen_r;
  // Commands arriving while one is in flight are dropped, not queued
  assign cmd_take    = ~frame_start & (bit_cnt_r == `CRP_LAST_CMD_BIT) &
                       in_word[`CRP_TAG_VALID] & in_word[`CRP_TAG_SLOT1] &
                       (in_word[39] | in_word[`CRP_TAG_SLOT2]) & ~busy;
  assign out_word    = {1'b1, reply_pend_r, reply_pend_r, 13'h0000,
                        1'b0, reply_idx_r, 12'h000,
                        reply_data_r, 4'h0};
  assign sdata_in_out = sdata_r;

  // Reset reaches the link side through its own two-stage synchroniser
  always_ff @(posedge bit_clk_in) begin
    lrst_s_r <= {lrst_s_r[0], rst_in};
  end

  always_ff @(posedge bit_clk_in) begin
    if (lrst) begin
      sync_prev_r <= 1'b0;
      bit_cnt_r   <= 8'h00;
      in_sh_r     <= 55'h0;
      out_sh_r    <= 56'h0;
      sdata_r     <= 1'b0;
    end else begin
      sync_prev_r <= sync_in;
      in_sh_r     <= in_word[54:0];
      if (frame_start) begin
        bit_cnt_r <= 8'h01;
        sdata_r   <= out_word[55];
        out_sh_r  <= {out_word[54:0], 1'b0};
      end else begin
        bit_cnt_r <= bit_cnt_r + 8'h01;
        sdata_r   <= out_sh_r[55];
        out_sh_r  <= {out_sh_r[54:0], 1'b0};
      end
    end
  end

  // Command capture and the toggle handshake toward the core
  always_ff @(posedge bit_clk_in) begin
    if (lrst) begin
      req_tgl_r  <= 1'b0;
      cmd_r      <= '0;
      ack_s_r    <= 3'h0;
      ack_seen_r <= 1'b0;
    end else begin
      ack_s_r <= {ack_s_r[1:0], ack_tgl_r};
      if (ack_evt)
        ack_seen_r <= ack_f;
      if (cmd_take) begin
        cmd_r.rd    <= in_word[39];
        cmd_r.index <= in_word[38:32];
        cmd_r.data  <= in_word[19:4];
        req_tgl_r   <= ~req_tgl_r;
      end
    end
  end

  // A finished read waits for the next frame; a new answer wins over
  // the clear at frame start so it is never lost
  always_ff @(posedge bit_clk_in) begin
    if (lrst) begin
      reply_pend_r <= 1'b0;
      reply_idx_r  <= 7'h00;
      reply_data_r <= 16'h0000;
    end else if (ack_evt && cmd_r.rd) begin
      reply_pend_r <= 1'b1;
      reply_idx_r  <= cmd_r.index;
      reply_data_r <= rdata_r;
    end else if (frame_start) begin
      reply_pend_r <= 1'b0;
    end
  end

endmodule // crp_regs

//--- rtl/crp_params.svh
// Register map, field positions, reset values and link frame constants
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

`define CRP_IDX_INPUT_SEL   7'h1A
`define CRP_IDX_RECORD_GAIN 7'h1C
`define CRP_IDX_PATH_SEL    7'h20
`define CRP_IDX_POWER       7'h26
`define CRP_IDX_EXT_ID      7'h28

`define CRP_RST_INPUT_SEL   16'h0000
`define CRP_RST_RECORD_GAIN 16'h8000
`define CRP_RST_PATH_SEL    16'h0000
`define CRP_RST_POWER_CTRL  8'h00
`define CRP_RST_READY       4'hF

`define CRP_WMASK_INPUT_SEL 16'h0707
`define CRP_WMASK_GAIN      16'h8F0F
`define CRP_WMASK_PATH      16'h0380

`define CRP_BIT_MUTE        15
`define CRP_BIT_MONO_SRC    9
`define CRP_BIT_MIC_SEL     8
`define CRP_BIT_LOOPBACK    7
`define CRP_PWR_EXT_AMP     7
`define CRP_PWR_ICLK        5
`define CRP_PWR_LINK        4
`define CRP_RDY_ADC         0
`define CRP_RDY_DAC         1

`define CRP_SPEC_REV        2'h1
`define CRP_STRAP_DELAY     2'h3

`define CRP_LAST_CMD_BIT    8'h37
`define CRP_TAG_VALID       55
`define CRP_TAG_SLOT1       54
`define CRP_TAG_SLOT2       53

`endif

//--- rtl/crp_pkg.sv
// Types shared by the record and power control register block
package crp_pkg;

  typedef struct packed {
    logic       rd;
    logic [6:0] index;
    logic [15:0] data;
  } crp_cmd_t;

  typedef struct packed {
    logic [2:0] left_source_sel;
    logic [2:0] right_source_sel;
    logic [3:0] left_record_gain;
    logic [3:0] right_record_gain;
    logic       adc_input_mute;
    logic       mono_from_mic;
    logic       mic_input_sel;
    logic       converter_loopback_en;
  } crp_record_ctrl_t;

  typedef struct packed {
    logic ext_amp_powerdown;
    logic headphone_amp_off;
    logic internal_clock_off;
    logic link_powerdown;
    logic mixer_and_vref_off;
    logic mixer_off_vref_on;
    logic dac_powerdown;
    logic adc_powerdown;
  } crp_power_ctrl_t;

endpackage

//--- verif/crp_regs_assertions.sv
// Port-level checks for the record and power control register block
`timescale 1ns/10ps
module crp_regs_checker (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  input  wire logic                 sync_in,
  input  wire logic [3:0]           ready_flags_in,
  input  wire logic                 serial_port_exclusive_bit_in,
  input  wire crp_pkg::crp_record_ctrl_t record_ctrl_out,
  input  wire crp_pkg::crp_power_ctrl_t  power_ctrl_out,
  input  wire logic                 ext_amp_powerdown_out,
  input  wire logic                 adc_capture_valid_out,
  input  wire logic                 dac_accept_out
);
  import crp_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_amp_pin_mirror: assert property (
    ext_amp_powerdown_out == power_ctrl_out.ext_amp_powerdown)
    else $error("amplifier pin differs from its control bit");
  a_exclusive_amp_zero: assert property (
    serial_port_exclusive_bit_in |=> !ext_amp_powerdown_out)
    else $error("amplifier pin set while exclusive bit is set");
  a_adc_pd_gate: assert property (
    power_ctrl_out.adc_powerdown |=> !adc_capture_valid_out)
    else $error("capture valid while converters are powered down");
  a_adc_ready_gate: assert property (
    !ready_flags_in[0] [*6] |=> !adc_capture_valid_out)
    else $error("capture valid while converter not ready");
  a_dac_pd_gate: assert property (
    power_ctrl_out.dac_powerdown |=> !dac_accept_out)
    else $error("playback accepted while converters are powered down");
  a_clock_off_sticky: assert property (
    power_ctrl_out.internal_clock_off |=> power_ctrl_out.internal_clock_off)
    else $error("clock disable cleared without cold reset");
  a_link_wake: assert property (
    sync_in [*6] |=> !power_ctrl_out.link_powerdown)
    else $error("link stays powered down after sync");
  a_reset_defaults: assert property (
    $fell(rst_in) |-> record_ctrl_out.adc_input_mute
      && record_ctrl_out.left_record_gain == 4'h0
      && record_ctrl_out.right_record_gain == 4'h0
      && power_ctrl_out == 8'h00)
    else $error("wrong control values after reset");
endmodule // crp_regs_checker

bind crp_regs crp_regs_checker u_chk (
  .clock_in(clock_in), .rst_in(rst_in), .sync_in(sync_in),
  .ready_flags_in(ready_flags_in),
  .serial_port_exclusive_bit_in(serial_port_exclusive_bit_in),
  .record_ctrl_out(record_ctrl_out), .power_ctrl_out(power_ctrl_out),
  .ext_amp_powerdown_out(ext_amp_powerdown_out),
  .adc_capture_valid_out(adc_capture_valid_out),
  .dac_accept_out(dac_accept_out));

//--- verif/crp_link_model.sv
// Controller end of the serial link: frames commands, gathers replies
`timescale 1ns/10ps
module crp_link_model (
  input  wire logic bit_clk_in,
  input  wire logic link_rx_in,
  output logic      sync_out,
  output logic      link_tx_out
);
  initial begin
    sync_out = 1'b0;
    link_tx_out = 1'b0;
  end

  // One 256-bit frame; idle frames still carry stray slot data on purpose
  task automatic xfer(input logic cmd, input logic rd,
                      input logic [6:0] idx, input logic [15:0] data,
                      output logic [0:255] rx);
    logic [0:255] f;
    f = '0;
    f[0] = cmd;
    f[1] = 1'b1;
    f[2] = ~rd;
    f[16] = rd;
    f[17:23] = idx;
    f[36:51] = data;
    for (int i = 0; i <= 256; i++) begin
      @(posedge bit_clk_in);
      if (i < 256) begin
        sync_out <= (i < 16);
        link_tx_out <= f[i];
      end
      @(negedge bit_clk_in);
      if (i > 0) rx[i-1] = link_rx_in;
    end
  endtask
endmodule // crp_link_model

//--- verif/test_crp_regs.sv
// Self-checking bench for the record and power control registers
`timescale 1ns/10ps
module test_crp_regs;
  import crp_pkg::*;
  logic             clock_in;
  logic             rst_in;
  logic             bit_clk;
  logic             sync;
  logic             tx;
  logic             rx;
  logic [1:0]       id_pins;
  logic             excl;
  logic [3:0]       ready;
  crp_record_ctrl_t rec;
  crp_power_ctrl_t  pwr;
  logic             amp_pin;
  logic             cap_ok;
  logic             dac_ok;
  logic [0:255]     fr;
  int               bad_count = 0;
  int               samples_checked = 0;
  int               cycles = 0;

  crp_regs u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .bit_clk_in(bit_clk), .sync_in(sync), .sdata_out_in(tx),
    .sdata_in_out(rx), .codec_id_pins_in(id_pins),
    .serial_port_exclusive_bit_in(excl), .ready_flags_in(ready),
    .record_ctrl_out(rec), .power_ctrl_out(pwr),
    .ext_amp_powerdown_out(amp_pin), .adc_capture_valid_out(cap_ok),
    .dac_accept_out(dac_ok));
  crp_link_model u_link (.bit_clk_in(bit_clk), .link_rx_in(rx),
    .sync_out(sync), .link_tx_out(tx));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    bit_clk = 1'b0;
    #7;
    forever #24 bit_clk = ~bit_clk;
  end

  task automatic check(input string what, input logic [17:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic do_reset;
    @(posedge clock_in);
    rst_in <= 1'b1;
    clk(12);
    rst_in <= 1'b0;
    clk(20);
  endtask

  // A spacing frame follows every command, as the link asks
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    u_link.xfer(1'b1, 1'b0, idx, d, fr);
    u_link.xfer(1'b0, 1'b0, idx, ~d, fr);
  endtask

  task automatic rchk(input string what, input logic [6:0] idx,
                      input logic [15:0] exp);
    logic [15:0] v;
    u_link.xfer(1'b1, 1'b1, idx, 16'h0000, fr);
    for (int n = 0; n < 3; n++) begin
      u_link.xfer(1'b0, 1'b1, idx, 16'hFFFF, fr);
      if (fr[1] === 1'b1) break;
    end
    v = (fr[1] === 1'b1 && fr[17:23] === idx) ? fr[36:51] : 16'hDEAD;
    check(what, {2'b00, v}, {2'b00, exp});
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    rst_in = 1'b1;
    id_pins = 2'b10;
    excl = 1'b0;
    ready = 4'hF;
    do_reset();
    rchk("gain reset", 7'h1C, 16'h8000);
    rchk("path reset", 7'h20, 16'h0000);
    rchk("power reset", 7'h26, 16'h000F);
    rchk("source reset", 7'h1A, 16'h0000);
    rchk("ext id", 7'h28, 16'h8600);
    rchk("unmapped", 7'h02, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      wr(7'h1A, {5'h00, c[2:0], 5'h00, ~c[2:0]});
      check("sources", {12'h0, rec[17:12]}, {12'h0, c[2:0], ~c[2:0]});
    end
    rchk("source sel", 7'h1A, 16'h0700);
    wr(7'h1C, 16'h7F03);
    check("gain", rec, {6'o70, 8'hF3, 4'h0});
    wr(7'h1C, 16'h8FF0);
    rchk("gain mute", 7'h1C, 16'h8F00);
    wr(7'h20, 16'hFFFF);
    check("path all", {15'h0, rec[2:0]}, 18'h00007);
    rchk("path read", 7'h20, 16'h0380);
    wr(7'h20, 16'h0100);
    check("mic only", {15'h0, rec[2:0]}, 18'h00002);
    @(posedge clock_in);
    ready <= 4'h5;
    rchk("ready flags", 7'h26, 16'h0005);
    u_link.xfer(1'b1, 1'b0, 7'h26, 16'hFFFF, fr);
    clk(10);
    check("power all", {10'h0, pwr}, 18'h000FF);
    check("amp pin", {17'h0, amp_pin}, 18'h1);
    check("gates off", {16'h0, cap_ok, dac_ok}, 18'h0);
    u_link.xfer(1'b0, 1'b0, 7'h26, 16'h0000, fr);
    rchk("link woken", 7'h26, 16'hEF05);
    @(posedge clock_in);
    excl <= 1'b1;
    clk(3);
    check("amp excl", {17'h0, amp_pin}, 18'h0);
    rchk("amp hidden", 7'h26, 16'h6F05);
    wr(7'h26, 16'h8000);
    rchk("clock sticky", 7'h26, 16'h2005);
    @(posedge clock_in);
    excl <= 1'b0;
    wr(7'h26, 16'h8000);
    check("amp set", {17'h0, amp_pin}, 18'h1);
    wr(7'h26, 16'h0000);
    check("gates", {16'h0, cap_ok, dac_ok}, 18'h2);
    @(posedge clock_in);
    ready <= 4'hF;
    clk(8);
    check("gates ready", {16'h0, cap_ok, dac_ok}, 18'h3);
    @(posedge clock_in);
    ready <= 4'hE;
    clk(8);
    check("adc not ready", {17'h0, cap_ok}, 18'h0);
    wr(7'h28, 16'h0000);
    rchk("id read only", 7'h28, 16'h8600);
    @(posedge clock_in);
    ready <= 4'hF;
    // Second cold reset is the only way out of the clock disable
    do_reset();
    rchk("power cold", 7'h26, 16'h000F);
    rchk("gain cold", 7'h1C, 16'h8000);
    complete_run();
  end
endmodule // test_crp_regs
